// ### logic/cid_pkg.sv
/*
 * Shared constants for the instruction decode core: field positions,
 * operation codes, selector codes and the small enumerations.
 * Assumes fixed 32-bit instruction words from a word-aligned fetch.
 */
// Functional notes
// - each instruction is one aligned 32-bit word in immediate, jump or register format
// - extract 6-bit major code, 6-bit selector and four 5-bit register/shift fields
// - immediate format has 16-bit immediate; jump format has 26-bit target field
// - load/store address is base register plus sign-extended 16-bit offset only
// - instruction using a just-loaded register stalls until the load data arrives
// - address names the lowest-addressed byte: MSB in big-endian, LSB in little-endian
// - lanes from size and low address bits; word 0, triple 0/1, half 0/2, byte any
// - any other size/offset pair raises an address error and performs no access
// - multiplies go to the multiplier while later instructions keep flowing
// - move from upper/lower product stalls until the product is ready
// - computation takes two registers, or one register and a 16-bit immediate
// - jumps and branches act one instruction late; delay slot executes unless an untaken likely branch nullifies it
// - jump target is 26-bit field shifted by two with upper four pc bits
// - register jumps take the full 32-bit register value as new pc
// - branch target is delay-slot address plus sign-extended offset shifted by two
// - untaken likely branch nullifies its delay-slot instruction
// - count-leading-ones scans from the top bit and gives 32 for all ones
// - count-leading-zeros scans from the top bit and gives 32 for all zeros
`default_nettype none
package cid_pkg;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MAJOR_HI = 31;
    localparam int MAJOR_LO = 26;
    localparam int SRC_HI   = 25;
    localparam int SRC_LO   = 21;
    localparam int SEC_HI   = 20;
    localparam int SEC_LO   = 16;
    localparam int DST_HI   = 15;
    localparam int DST_LO   = 11;
    localparam int SHF_HI   = 10;
    localparam int SHF_LO   = 6;
    localparam int FUN_HI   = 5;
    localparam int IMM_HI   = 15;
    localparam int JMP_HI   = 25;
    localparam logic [31:0] PC_STEP = 32'h0000_0004;

    // ------------------------------------------------------------
    // major codes, selectors
    // ------------------------------------------------------------
    localparam logic [5:0] OP_SPECIAL  = 6'h00;
    localparam logic [5:0] OP_REGIMM   = 6'h01;
    localparam logic [5:0] OP_J        = 6'h02;
    localparam logic [5:0] OP_JAL      = 6'h03;
    localparam logic [5:0] OP_BEQ      = 6'h04;
    localparam logic [5:0] OP_BNE      = 6'h05;
    localparam logic [5:0] OP_BLEZ     = 6'h06;
    localparam logic [5:0] OP_BGTZ     = 6'h07;
    localparam logic [5:0] OP_BEQL     = 6'h14;
    localparam logic [5:0] OP_BNEL     = 6'h15;
    localparam logic [5:0] OP_BLEZL    = 6'h16;
    localparam logic [5:0] OP_BGTZL    = 6'h17;
    localparam logic [5:0] OP_SPECIAL2 = 6'h1C;
    localparam logic [5:0] OP_LB       = 6'h20;
    localparam logic [5:0] OP_LH       = 6'h21;
    localparam logic [5:0] OP_LW       = 6'h23;
    localparam logic [5:0] OP_LBU      = 6'h24;
    localparam logic [5:0] OP_LHU      = 6'h25;
    localparam logic [5:0] OP_SB       = 6'h28;
    localparam logic [5:0] OP_SH       = 6'h29;
    localparam logic [5:0] OP_SW       = 6'h2B;
    localparam logic [5:0] FN_JR       = 6'h08;
    localparam logic [5:0] FN_JALR     = 6'h09;
    localparam logic [5:0] FN_MFUPPER  = 6'h10;
    localparam logic [5:0] FN_MFLOWER  = 6'h12;
    localparam logic [5:0] FN_MULT     = 6'h18;
    localparam logic [5:0] FN_DIVU     = 6'h1B;
    localparam logic [5:0] FN2_MUL     = 6'h02;
    localparam logic [5:0] FN2_MSUBU   = 6'h05;
    localparam logic [5:0] FN2_ZEROS   = 6'h20;
    localparam logic [5:0] FN2_ONES    = 6'h21;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {FMT_IMM, FMT_JUMP, FMT_REG} cid_fmt_e;
    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_TRIPLE, SZ_WORD} cid_size_e;
    typedef enum logic {MUL_IDLE, MUL_BUSY} cid_mul_e;
endpackage
`default_nettype wire

// ### logic/cid_lane_map.sv
/*
 * Byte lane selection and alignment check for one data access.
 * Assumes size and offset come from the decode core in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module cid_lane_map (
    // access
    input  wire cid_pkg::cid_size_e access_size,
    input  wire logic [1:0]         byte_offset,
    input  wire logic               big_endian,
    // result
    output logic [3:0]              byte_lanes,
    output logic                    misaligned
);
    // little-endian mask; big-endian is its mirror
    function automatic logic [3:0] le_mask(input cid_pkg::cid_size_e s, input logic [1:0] o);
        case (s)
            cid_pkg::SZ_BYTE:   return 4'h1 << o;
            cid_pkg::SZ_HALF:   return 4'h3 << o;
            cid_pkg::SZ_TRIPLE: return 4'h7 << o;
            default:            return 4'hF;
        endcase
    endfunction

    // legal pairs only; anything else gives no lanes at all
    always_comb begin
        logic [3:0] m;
        m = le_mask(access_size, byte_offset);
        case (access_size)
            cid_pkg::SZ_BYTE:   misaligned = 1'b0;
            cid_pkg::SZ_HALF:   misaligned = byte_offset[0];
            cid_pkg::SZ_TRIPLE: misaligned = byte_offset[1];
            default:            misaligned = (byte_offset != 2'h0);
        endcase
        if (misaligned) begin
            byte_lanes = 4'h0;
        end else if (big_endian) begin
            byte_lanes = {m[0], m[1], m[2], m[3]};
        end else begin
            byte_lanes = m;
        end
    end
endmodule
`default_nettype wire

// ### logic/cid_lead_count.sv
/*
 * Leading ones / leading zeros counter for a 32-bit word.
 * Assumes the caller registers the result.
 */
`timescale 1ns/1ps
`default_nettype none
module cid_lead_count (
    // operand
    input  wire logic [31:0] word,
    input  wire logic        count_ones,
    // result
    output logic [5:0]       count
);
    // scan from the top bit; the run ends at the first differing bit
    function automatic logic [5:0] lead_run(input logic [31:0] w, input logic ones);
        logic [5:0] n;
        logic       run;
        n = 6'h00;
        run = 1'b1;
        for (int i = 31; i >= 0; i--) begin
            if (run && (w[i] == ones)) begin
                n = n + 6'h01;
            end else begin
                run = 1'b0;
            end
        end
        return n;
    endfunction

    always_comb begin
        count = lead_run(word, count_ones);
    end
endmodule
`default_nettype wire

// ### logic/cid_core.sv
/*
 * Instruction decode core: field split, load/store address and lanes,
 * load-use and product interlocks, delayed jumps and branches, and
 * leading-bit counts. All outputs are registered.
 * Assumes the fetch side honours instr_ready and that the operand ports
 * always carry the registers named by the instruction being decided.
 */
`timescale 1ns/1ps
`default_nettype none
module cid_core (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // instruction from fetch
    input  wire logic         instr_valid,
    input  wire logic [31:0]  instr_word,
    input  wire logic [31:0]  instr_pc,
    output logic              instr_ready,
    // operands and configuration
    input  wire logic [31:0]  source_value,
    input  wire logic [31:0]  second_value,
    input  wire logic         big_endian,
    // completions
    input  wire logic         load_ready,
    input  wire logic         product_ready,
    // decoded fields
    output logic              issue_valid,
    output cid_pkg::cid_fmt_e instr_format,
    output logic [5:0]        major_code_field,
    output logic [4:0]        source_reg_field,
    output logic [4:0]        second_source_field,
    output logic [4:0]        dest_reg_field,
    output logic [4:0]        shift_count_field,
    output logic [5:0]        function_field,
    output logic [15:0]       imm_field,
    output logic [25:0]       jump_field,
    // data access
    output logic              mem_read,
    output logic              mem_write,
    output logic [31:0]       eff_addr,
    output logic [3:0]        byte_lanes,
    output logic              addr_error,
    // multiplier
    output logic              mul_start,
    output logic              move_from_upper_product,
    output logic              move_from_lower_product,
    // leading count
    output logic              count_valid,
    output logic [5:0]        count_result,
    // control flow
    output logic              nullify,
    output logic              redirect_valid,
    output logic [31:0]       redirect_pc
);
    // checks share the core clock
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic              ready;
        logic              hold_valid;
        logic [31:0]       hold_word;
        logic [31:0]       hold_pc;
        logic              load_pend;
        logic [4:0]        load_reg;
        cid_pkg::cid_mul_e mul_state;
        logic              slot_pend;
        logic              slot_taken;
        logic              slot_null;
        logic [31:0]       slot_target;
        logic              issue;
        cid_pkg::cid_fmt_e fmt;
        logic [31:0]       word;
        logic              rd;
        logic              wr;
        logic [31:0]       addr;
        logic [3:0]        lanes;
        logic              aerr;
        logic              mstart;
        logic              mfu;
        logic              mfl;
        logic              cvalid;
        logic [5:0]        count;
        logic              nul;
        logic              redir;
        logic [31:0]       redir_pc;
    } cid_core_s;

    cid_core_s st;
    cid_core_s next_st;

    function automatic logic [31:0] sext16(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction

    // branch condition on the two operands
    function automatic logic br_cond(input logic [5:0] op, input logic [4:0] rt,
                                     input logic [31:0] a, input logic [31:0] b);
        case (op)
            cid_pkg::OP_BEQ, cid_pkg::OP_BEQL:   return a == b;
            cid_pkg::OP_BNE, cid_pkg::OP_BNEL:   return a != b;
            cid_pkg::OP_BLEZ, cid_pkg::OP_BLEZL: return a[31] || (a == 32'h0000_0000);
            cid_pkg::OP_BGTZ, cid_pkg::OP_BGTZL: return !a[31] && (a != 32'h0000_0000);
            cid_pkg::OP_REGIMM:                  return rt[0] ? !a[31] : a[31];
            default:                             return 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // decode of the instruction being decided
    // ------------------------------------------------------------
    logic              cur_valid;
    logic [31:0]       cur_word;
    logic [31:0]       cur_pc;
    logic [5:0]        op;
    logic [5:0]        fn;
    logic [4:0]        rs;
    logic [4:0]        rt;
    logic [15:0]       cur_imm;
    logic [25:0]       cur_jt;
    logic              is_load;
    logic              is_store;
    logic              is_muldiv;
    logic              is_mfhilo;
    logic              is_count;
    logic              is_branch;
    logic              is_likely;
    logic              is_jreg;
    logic              is_jimm;
    logic              hazard_load;
    logic              hazard_mul;
    logic              issue_now;
    logic              null_this;
    cid_pkg::cid_size_e acc_size;
    logic [31:0]       cur_addr;
    logic [3:0]        lanes;
    logic              misaligned;
    logic [5:0]        lead;

    // a held instruction takes precedence over the port
    assign cur_valid = st.hold_valid || (instr_valid && st.ready);
    assign cur_word  = st.hold_valid ? st.hold_word : instr_word;
    assign cur_pc    = st.hold_valid ? st.hold_pc : instr_pc;
    assign op        = cur_word[cid_pkg::MAJOR_HI:cid_pkg::MAJOR_LO];
    assign fn        = cur_word[cid_pkg::FUN_HI:0];
    assign rs        = cur_word[cid_pkg::SRC_HI:cid_pkg::SRC_LO];
    assign rt        = cur_word[cid_pkg::SEC_HI:cid_pkg::SEC_LO];
    assign cur_imm   = cur_word[cid_pkg::IMM_HI:0];
    assign cur_jt    = cur_word[cid_pkg::JMP_HI:0];

    // instruction classes
    assign is_load   = (op == cid_pkg::OP_LB) || (op == cid_pkg::OP_LH) ||
                       (op == cid_pkg::OP_LW) || (op == cid_pkg::OP_LBU) ||
                       (op == cid_pkg::OP_LHU);
    assign is_store  = (op == cid_pkg::OP_SB) || (op == cid_pkg::OP_SH) ||
                       (op == cid_pkg::OP_SW);
    assign is_muldiv = ((op == cid_pkg::OP_SPECIAL) && (fn >= cid_pkg::FN_MULT) &&
                        (fn <= cid_pkg::FN_DIVU)) ||
                       ((op == cid_pkg::OP_SPECIAL2) && (fn <= cid_pkg::FN2_MSUBU) &&
                        (fn != 6'h03));
    assign is_mfhilo = (op == cid_pkg::OP_SPECIAL) &&
                       ((fn == cid_pkg::FN_MFUPPER) || (fn == cid_pkg::FN_MFLOWER));
    assign is_count  = (op == cid_pkg::OP_SPECIAL2) &&
                       ((fn == cid_pkg::FN2_ZEROS) || (fn == cid_pkg::FN2_ONES));
    assign is_jimm   = (op == cid_pkg::OP_J) || (op == cid_pkg::OP_JAL);
    assign is_jreg   = (op == cid_pkg::OP_SPECIAL) &&
                       ((fn == cid_pkg::FN_JR) || (fn == cid_pkg::FN_JALR));
    assign is_branch = ((op >= cid_pkg::OP_BEQ) && (op <= cid_pkg::OP_BGTZ)) ||
                       ((op >= cid_pkg::OP_BEQL) && (op <= cid_pkg::OP_BGTZL)) ||
                       ((op == cid_pkg::OP_REGIMM) && (rt[3:2] == 2'b00));
    assign is_likely = (op == cid_pkg::OP_REGIMM) ? rt[1] : op[4];

    // size from the opcode low bits: byte, half, word
    always_comb begin
        case (op[1:0])
            2'h0:    acc_size = cid_pkg::SZ_BYTE;
            2'h1:    acc_size = cid_pkg::SZ_HALF;
            default: acc_size = cid_pkg::SZ_WORD;
        endcase
    end

    // base plus sign-extended offset is the only addressing mode
    assign cur_addr = source_value + sext16(cur_imm);

    cid_lane_map u_lanes (
        .access_size (acc_size),
        .byte_offset (cur_addr[1:0]),
        .big_endian  (big_endian),
        .byte_lanes  (lanes),
        .misaligned  (misaligned)
    );

    cid_lead_count u_lead (
        .word       (source_value),
        .count_ones (fn[0]),
        .count      (lead)
    );

    // interlocks: a stale operand or an unfinished product holds the instruction
    assign hazard_load = st.load_pend && !load_ready && (st.load_reg != 5'h00) &&
                         ((rs == st.load_reg) || (rt == st.load_reg));
    assign hazard_mul  = (st.mul_state == cid_pkg::MUL_BUSY) && !product_ready &&
                         (is_mfhilo || is_muldiv);
    assign issue_now   = cur_valid && !hazard_load && !hazard_mul;
    assign null_this   = st.slot_pend && st.slot_null;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // hold the blocked instruction; ready drops the cycle after
        next_st.ready      = !(cur_valid && !issue_now);
        next_st.hold_valid = cur_valid && !issue_now;
        if (!st.hold_valid) begin
            next_st.hold_word = instr_word;
            next_st.hold_pc   = instr_pc;
        end
        // pending load: a new load wins over a completion in the same cycle
        if (issue_now && is_load && !null_this && !misaligned) begin
            next_st.load_pend = 1'b1;
            next_st.load_reg  = rt;
        end else if (load_ready) begin
            next_st.load_pend = 1'b0;
        end
        // multiplier runs beside the pipe; only product moves and new multiplies wait
        case (st.mul_state)
            cid_pkg::MUL_IDLE: begin
                if (issue_now && is_muldiv && !null_this) begin
                    next_st.mul_state = cid_pkg::MUL_BUSY;
                end
            end
            cid_pkg::MUL_BUSY: begin
                if (issue_now && is_muldiv && !null_this) begin
                    next_st.mul_state = cid_pkg::MUL_BUSY;
                end else if (product_ready) begin
                    next_st.mul_state = cid_pkg::MUL_IDLE;
                end
            end
            default: next_st.mul_state = cid_pkg::MUL_IDLE;
        endcase
        // issue pulses and fields
        next_st.issue    = issue_now;
        next_st.word     = cur_word;
        next_st.fmt      = is_jimm ? cid_pkg::FMT_JUMP :
                           ((op == cid_pkg::OP_SPECIAL) || (op == cid_pkg::OP_SPECIAL2)) ?
                           cid_pkg::FMT_REG : cid_pkg::FMT_IMM;
        next_st.addr     = cur_addr;
        next_st.lanes    = (is_load || is_store) ? lanes : 4'h0;
        next_st.rd       = issue_now && !null_this && is_load && !misaligned;
        next_st.wr       = issue_now && !null_this && is_store && !misaligned;
        next_st.aerr     = issue_now && !null_this && (is_load || is_store) && misaligned;
        next_st.mstart   = issue_now && !null_this && is_muldiv;
        next_st.mfu      = issue_now && !null_this && is_mfhilo && !fn[1];
        next_st.mfl      = issue_now && !null_this && is_mfhilo && fn[1];
        next_st.cvalid   = issue_now && !null_this && is_count;
        next_st.count    = lead;
        next_st.nul      = issue_now && null_this;
        next_st.redir    = issue_now && st.slot_pend && st.slot_taken;
        next_st.redir_pc = st.slot_target;
        if (issue_now) begin
            next_st.slot_pend = 1'b0;
            // a transfer in the delay slot replaces the pending one
            if (!null_this && (is_branch || is_jimm || is_jreg)) begin
                next_st.slot_pend  = 1'b1;
                next_st.slot_taken = is_branch ? br_cond(op, rt, source_value, second_value)
                                               : 1'b1;
                next_st.slot_null  = is_branch && is_likely &&
                                     !br_cond(op, rt, source_value, second_value);
                if (is_jimm) begin
                    next_st.slot_target = {cur_pc[31:28], cur_jt, 2'b00};
                end else if (is_jreg) begin
                    next_st.slot_target = source_value;
                end else begin
                    next_st.slot_target = cur_pc + cid_pkg::PC_STEP +
                                          (sext16(cur_imm) << 2);
                end
            end
        end
    end

    // single register for all state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st       <= '0;
            st.ready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign instr_ready             = st.ready;
    assign issue_valid             = st.issue;
    assign instr_format            = st.fmt;
    assign major_code_field        = st.word[cid_pkg::MAJOR_HI:cid_pkg::MAJOR_LO];
    assign source_reg_field        = st.word[cid_pkg::SRC_HI:cid_pkg::SRC_LO];
    assign second_source_field     = st.word[cid_pkg::SEC_HI:cid_pkg::SEC_LO];
    assign dest_reg_field          = st.word[cid_pkg::DST_HI:cid_pkg::DST_LO];
    assign shift_count_field       = st.word[cid_pkg::SHF_HI:cid_pkg::SHF_LO];
    assign function_field          = st.word[cid_pkg::FUN_HI:0];
    assign imm_field               = st.word[cid_pkg::IMM_HI:0];
    assign jump_field              = st.word[cid_pkg::JMP_HI:0];
    assign mem_read                = st.rd;
    assign mem_write               = st.wr;
    assign eff_addr                = st.addr;
    assign byte_lanes              = st.lanes;
    assign addr_error              = st.aerr;
    assign mul_start               = st.mstart;
    assign move_from_upper_product = st.mfu;
    assign move_from_lower_product = st.mfl;
    assign count_valid             = st.cvalid;
    assign count_result            = st.count;
    assign nullify                 = st.nul;
    assign redirect_valid          = st.redir;
    assign redirect_pc             = st.redir_pc;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_field_split: assert property (issue_now |=> st.word == $past(cur_word))
        else $error("decoded fields differ from the issued word");
    a_load_stall: assert property (cur_valid && hazard_load |=>
        !issue_valid && !instr_ready) else $error("early load use");
    a_product_wait: assert property (hazard_mul |=>
        !move_from_upper_product && !move_from_lower_product) else $error("early product read");
    a_addr_error: assert property (issue_now && is_load && misaligned && !null_this |=>
        addr_error && !mem_read) else $error("misaligned load done");
    a_jump_target: assert property (issue_now && is_jimm && !null_this |=>
        st.slot_target == {$past(cur_pc[31:28]), $past(cur_jt), 2'b00})
        else $error("bad jump target");
    a_slot_nullify: assert property (issue_now && null_this |=>
        nullify && !mem_read && !mem_write && !mul_start) else $error("nullified slot acted");
endmodule
`default_nettype wire

// ### dv/cid_far_model.sv
/* far-side model: data memory and multiplier completion strobes.
   assumes the core raises mem_read and mul_start as one-cycle requests. */
`timescale 1ns/1ps
`default_nettype none
module cid_far_model (
    // clock
    input  wire logic clk,
    // requests from the core
    input  wire logic mem_read,
    input  wire logic mul_start,
    // completions
    output logic      load_ready,
    output logic      product_ready
);
    int unsigned ld_wait = 0;
    int unsigned mu_wait = 0;
    // ------------------------------------------------------------
    // completion delays
    // ------------------------------------------------------------
    // slow answers, so the core's interlocks really have to wait
    always @(posedge clk) begin
        if (mem_read)
            ld_wait <= 3;
        else if (ld_wait != 0)
            ld_wait <= ld_wait - 1;
        if (mul_start)
            mu_wait <= 5;
        else if (mu_wait != 0)
            mu_wait <= mu_wait - 1;
    end
    assign load_ready    = (ld_wait == 1);
    assign product_ready = (mu_wait == 1);
endmodule
`default_nettype wire

// ### dv/cpu_instruction_decode_core_test.sv
/* self-checking bench for the decode core with the far-side model.
   assumes registered outputs that appear within a few cycles of issue. */
`timescale 1ns/1ps
`default_nettype none
module cpu_instruction_decode_core_test;
    logic clk = 0, rst_n = 0, instr_valid = 0, big_endian = 0, load_ready, product_ready;
    logic [31:0] instr_word = 0, instr_pc = 0, source_value = 0, second_value = 0;
    logic instr_ready, issue_valid, mem_read, mem_write, addr_error, mul_start, nullify;
    logic move_from_upper_product, move_from_lower_product, count_valid, redirect_valid;
    cid_pkg::cid_fmt_e instr_format;
    logic [5:0] major_code_field, function_field, count_result, got_cnt;
    logic [4:0] source_reg_field, second_source_field, dest_reg_field, shift_count_field;
    logic [15:0] imm_field;
    logic [25:0] jump_field;
    logic [3:0] byte_lanes;
    logic [31:0] eff_addr, redirect_pc, got_pc;
    logic got_redir = 0, got_null = 0;
    int n_fail = 0, checks = 0, cycles = 0;
    cid_core DUT (.*);
    cid_far_model far (.clk(clk), .mem_read(mem_read), .mul_start(mul_start),
                       .load_ready(load_ready), .product_ready(product_ready));
    // ------------------------------------------------------------
    // clock, timeout, sticky capture of pulsed results
    // ------------------------------------------------------------
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_fail = n_fail + 1;
            final_report();
        end
    end
    always @(negedge clk) begin
        if (redirect_valid === 1'b1) begin
            got_redir = 1;
            got_pc = redirect_pc;
        end
        if (nullify === 1'b1)
            got_null = 1;
        if (count_valid === 1'b1)
            got_cnt = count_result;
    end
    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // hold the request until accepted, then wait for the decoded issue
    task automatic issue(input logic [31:0] w, input logic [31:0] pc);
        int n;
        @(negedge clk);
        {instr_word, instr_pc, instr_valid} = {w, pc, 1'b1};
        for (n = 0; n < 50 && instr_ready !== 1'b1; n++)
            @(negedge clk);
        @(negedge clk);
        instr_valid = 0;
        for (n = 0; n < 20 && issue_valid !== 1'b1; n++)
            @(negedge clk);
    endtask
    task automatic mem(input logic [5:0] op, input logic [1:0] off, input logic [3:0] le, input logic err);
        source_value = 32'h0000_1000;
        issue({op, 5'h02, 5'h03, 16'hFFF0 | off}, 32'h40);
        check("eff_addr", eff_addr, 32'h0FF0 + off);
        check("addr_error", addr_error, err);
        if (!err)
            check("lanes", byte_lanes, big_endian ? {le[0], le[1], le[2], le[3]} : le);
    endtask
    task automatic flow(input logic [31:0] w, input logic [31:0] pc, input logic [31:0] tgt);
        {got_redir, got_pc} = 0;
        issue(w, pc);
        issue(32'h0, pc + 4);
        repeat (4) @(negedge clk);
        check("redirect", {got_redir, got_pc}, {tgt != 0, tgt});
    endtask
    task automatic final_report();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1;
        issue({6'h00, 5'd3, 5'd7, 5'd9, 5'd4, 6'h20}, 32'h0);
        check("fields", {major_code_field, source_reg_field, second_source_field,
              dest_reg_field, shift_count_field, function_field}, 32'h0067_4920);
        for (int e = 0; e < 2; e++) begin
            big_endian = e[0];
            mem(cid_pkg::OP_LW, 2'd0, 4'hF, 0);
            mem(cid_pkg::OP_LW, 2'd2, 4'h0, 1);
            mem(cid_pkg::OP_LH, 2'd2, 4'hC, 0);
            mem(cid_pkg::OP_LH, 2'd1, 4'h0, 1);
            mem(cid_pkg::OP_LB, 2'd3, 4'h8, 0);
        end
        flow({cid_pkg::OP_J, 26'h0000123}, 32'hA000_0010, 32'hA000_048C);
        source_value = 32'h1234_5670;
        flow({6'h00, 5'd5, 15'h0, cid_pkg::FN_JR}, 32'h200, 32'h1234_5670);
        second_value = source_value;
        flow({cid_pkg::OP_BEQ, 5'd5, 5'd5, 16'hFFFF}, 32'h100, 32'h100);
        second_value = 32'h1;
        got_null = 0;
        flow({cid_pkg::OP_BEQL, 5'd5, 5'd6, 16'h0004}, 32'h300, 32'h0);
        check("nullify", got_null, 1'b1);
        source_value = 32'hFFFF_FFFF;
        issue({cid_pkg::OP_SPECIAL2, 5'd5, 5'd0, 5'd8, 5'd0, cid_pkg::FN2_ONES}, 32'h400);
        repeat (3) @(negedge clk);
        check("ones", got_cnt, 6'd32);
        source_value = 32'h0008_0000;
        issue({cid_pkg::OP_SPECIAL2, 5'd5, 5'd0, 5'd8, 5'd0, cid_pkg::FN2_ZEROS}, 32'h404);
        repeat (3) @(negedge clk);
        check("zeros", got_cnt, 6'd12);
        issue({6'h00, 5'd5, 5'd6, 10'h0, cid_pkg::FN_MULT}, 0);
        check("mul_start", mul_start, 1'b1);
        issue({6'h00, 20'h0, cid_pkg::FN_MFLOWER}, 4);
        check("move_lower", move_from_lower_product, 1'b1);
        check("mul_wait", far.mu_wait, 0);
        final_report();
    end
endmodule
`default_nettype wire
